// ===== token_node_pkg.sv
//==========================================================================
//==========================================================================
package token_node_pkg;
   // Register offsets.
   localparam logic [3:0] OFS_CONFIG = 4'h0;
   localparam logic [3:0] OFS_STATION_ID = 4'h1;
   localparam logic [3:0] OFS_AUX_CONFIG = 4'h3;
   localparam logic [3:0] OFS_PROBE_ID = 4'h4;
   localparam logic [3:0] OFS_DIAG = 4'h5;
   localparam logic [3:0] OFS_NEXT_ID = 4'h6;
   localparam logic [3:0] OFS_COMMAND = 4'h7;
   localparam logic [3:0] OFS_BUS_STATE = 4'h8;
   // Field positions.
   localparam int JOIN_EN_BIT = 5;
   localparam int SHORT_LIMIT_BIT = 0;
   localparam int TSEL_A_BIT = 1;
   localparam int TSEL_B_BIT = 2;
   localparam int DG_SELF = 7;
   localparam int DG_DUP = 6;
   localparam int DG_RCV = 5;
   localparam int DG_TOKEN = 4;
   localparam int DG_EXCESS = 3;
   localparam int DG_PROBE = 2;
   localparam int DG_SUCC = 1;
   localparam int DG_TXAV = 0;
   // Commands.
   localparam logic [7:0] CMD_DISABLE_TX = 8'h01;
   localparam logic [7:0] CMD_CLEAR_POWER_FLAGS = 8'h02;
   localparam logic [7:0] CMD_ENABLE_TX = 8'h03;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Buffer RAM check pattern and locations.
   localparam logic [7:0] RAM_CHECK_PATTERN = 8'hd1;
   localparam logic [10:0] RAM_LOC_CHECK = 11'h000;
   localparam logic [10:0] RAM_LOC_ID = 11'h001;
   // Refusal thresholds.
   localparam logic [6:0] REFUSE_LONG_WRAP = 7'h7f;
   localparam logic [6:0] REFUSE_SHORT_WRAP = 7'h03;
   // Duplicate detection deadlines in milliseconds.
   localparam int DUP_LIMIT_MS = 6720;
   localparam int DUP_LIMIT_SLOW_MS = 13440;
   // Write sequencer states.
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_CHECK = 3'b010,
      SEQ_ID = 3'b100
   } seq_state_t;
endpackage

// ===== token_node_join_diag.sv
`timescale 1ns/1ps
module token_node_join_diag
   import token_node_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port.
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Protocol engine events.
   input wire logic token_seen_i,
   input wire logic [7:0] token_dest_i,
   input wire logic token_from_self_i,
   input wire logic token_response_i,
   input wire logic token_to_me_i,
   input wire logic recv_timer_expired_i,
   input wire logic refusal_i,
   input wire logic accept_i,
   input wire logic [7:0] successor_id_i,
   // Line pin.
   input wire logic line_receive_input_i,
   // Core control.
   output logic core_awake_o,
   output logic token_pass_en_o,
   output logic reconfig_start_o,
   output logic excess_irq_o,
   output logic bus_detected_o,
   // Buffer RAM write port.
   output logic ram_we_o,
   output logic [10:0] ram_addr_o,
   output logic [7:0] ram_data_o
);
   //=======================================================================
   // Reset release
   //=======================================================================
   logic [1:0] rst_sync_r;
   logic rst_n;
   // The reset is applied at once and released through two flops.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   //=======================================================================
   // Register file
   //=======================================================================
   logic [7:0] config_r, station_id_r, aux_r, probe_id_r, next_id_r;
   logic [7:0] diag_r, diag_nxt;
   logic wr_cfg, wr_sid, wr_aux, wr_probe, wr_cmd, rd_diag;
   logic transmit_join_enable;
   assign wr_cfg = wr_i && addr_i == OFS_CONFIG;
   assign wr_sid = wr_i && addr_i == OFS_STATION_ID;
   assign wr_aux = wr_i && addr_i == OFS_AUX_CONFIG;
   assign wr_probe = wr_i && addr_i == OFS_PROBE_ID;
   assign wr_cmd = wr_i && addr_i == OFS_COMMAND;
   assign rd_diag = rd_i && addr_i == OFS_DIAG;
   assign transmit_join_enable = config_r[JOIN_EN_BIT];
   // Software-written registers.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         config_r <= RST_BYTE;
         station_id_r <= RST_BYTE;
         aux_r <= RST_BYTE;
         probe_id_r <= RST_BYTE;
      end else begin
         if (wr_cfg) config_r <= wdata_i;
         if (wr_sid) station_id_r <= wdata_i;
         if (wr_aux) aux_r <= wdata_i;
         if (wr_probe) probe_id_r <= wdata_i;
      end
   end

   // Read data stand in the cycle after the strobe; unmapped reads zero.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= RST_BYTE;
      end else if (rd_i) begin
         unique case (addr_i)
            OFS_CONFIG: rdata_o <= config_r;
            OFS_STATION_ID: rdata_o <= station_id_r;
            OFS_AUX_CONFIG: rdata_o <= aux_r;
            OFS_PROBE_ID: rdata_o <= probe_id_r;
            OFS_DIAG: rdata_o <= diag_r;
            OFS_NEXT_ID: rdata_o <= next_id_r;
            OFS_BUS_STATE: rdata_o <= {7'h00, bus_detected_o};
            default: rdata_o <= RST_BYTE;
         endcase
      end else begin
         rdata_o <= RST_BYTE;
      end
   end

   //=======================================================================
   // Bus interface determination
   //=======================================================================
   logic odd_write_r;
   // A write to an odd address followed by an odd read locks the bus type.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         odd_write_r <= 1'b0;
         bus_detected_o <= 1'b0;
      end else begin
         if (wr_i && addr_i[0]) odd_write_r <= 1'b1;
         if (rd_i && addr_i[0] && odd_write_r) bus_detected_o <= 1'b1;
      end
   end

   //=======================================================================
   // Wake-up, join and reconfiguration
   //=======================================================================
   logic join_pending;
   logic self_reconfig;
   // The core sleeps while the identifier is zero; a zero write keeps it so.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         core_awake_o <= 1'b0;
      end else begin
         core_awake_o <= station_id_r != RST_BYTE;
      end
   end

   assign join_pending = core_awake_o && transmit_join_enable &&
                         !token_pass_en_o;
   assign self_reconfig = join_pending || (core_awake_o &&
                          token_pass_en_o && recv_timer_expired_i);
   // Token passing only while awake and allowed to join.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         token_pass_en_o <= 1'b0;
         reconfig_start_o <= 1'b0;
      end else begin
         token_pass_en_o <= core_awake_o && transmit_join_enable;
         reconfig_start_o <= self_reconfig;
      end
   end

   //=======================================================================
   // Line receive synchroniser
   //=======================================================================
   logic [2:0] rx_sync_r;
   logic rx_level_r;
   // Three flops; a new level counts once the last two agree.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync_r <= 3'b000;
         rx_level_r <= 1'b0;
      end else begin
         rx_sync_r <= {rx_sync_r[1:0], line_receive_input_i};
         if (rx_sync_r[1] == rx_sync_r[2]) rx_level_r <= rx_sync_r[2];
      end
   end

   //=======================================================================
   // Duplicate and probe watch
   //=======================================================================
   logic [7:0] last_dest_r;
   logic last_valid_r, probe_armed_r;
   logic dup_hit, probe_hit;
   // Remember the destination of the last foreign token for its response.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         last_dest_r <= RST_BYTE;
         last_valid_r <= 1'b0;
         probe_armed_r <= 1'b0;
      end else begin
         if (token_seen_i && !token_from_self_i) begin
            last_dest_r <= token_dest_i;
            last_valid_r <= 1'b1;
         end else if (token_response_i) begin
            last_valid_r <= 1'b0;
         end
         if (wr_probe) probe_armed_r <= 1'b1;
      end
   end

   // A response shows a live node owns the destination identifier.
   assign dup_hit = core_awake_o && last_valid_r && token_response_i &&
                    last_dest_r == station_id_r;
   assign probe_hit = probe_armed_r && last_valid_r && token_response_i &&
                      last_dest_r == probe_id_r &&
                      last_dest_r != next_id_r;

   //=======================================================================
   // Successor tracking
   //=======================================================================
   logic succ_changed;
   // Latch the successor identity every cycle; succ_changed compares it with the stored one.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         next_id_r <= RST_BYTE;
      end else begin
         next_id_r <= successor_id_i;
      end
   end
   assign succ_changed = successor_id_i != next_id_r;

   //=======================================================================
   // Refusal counter and transmitter-available
   //=======================================================================
   logic [6:0] refuse_cnt_r;
   logic [6:0] refuse_wrap;
   logic refuse_limit;
   logic tx_abandoned_r;
   assign refuse_wrap = aux_r[SHORT_LIMIT_BIT] ? REFUSE_SHORT_WRAP :
                        REFUSE_LONG_WRAP;
   assign refuse_limit = refusal_i && refuse_cnt_r == refuse_wrap;

   // The count wraps so the flag can fire again after a clear.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         refuse_cnt_r <= 7'h00;
      end else if (accept_i) begin
         refuse_cnt_r <= 7'h00;
      end else if (refusal_i) begin
         refuse_cnt_r <= refuse_limit ? 7'h00 :
                         refuse_cnt_r + 7'h01;
      end
   end

   // Disable command waits for the next token to free the transmitter.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_abandoned_r <= 1'b0;
      end else if (wr_cmd && wdata_i == CMD_DISABLE_TX) begin
         tx_abandoned_r <= 1'b1;
      end else if (token_to_me_i) begin
         tx_abandoned_r <= 1'b0;
      end
   end

   //=======================================================================
   // Diagnostic status
   //=======================================================================
   // Reads clear the flags except DG_EXCESS and DG_TXAV, but an event in the same cycle wins.
   always_comb begin
      diag_nxt = diag_r;
      if (rd_diag) begin
         diag_nxt[DG_SELF] = 1'b0;
         diag_nxt[DG_DUP] = 1'b0;
         diag_nxt[DG_RCV] = 1'b0;
         diag_nxt[DG_TOKEN] = 1'b0;
         diag_nxt[DG_PROBE] = 1'b0;
         diag_nxt[DG_SUCC] = 1'b0;
      end
      if (wr_cmd && wdata_i == CMD_CLEAR_POWER_FLAGS) begin
         diag_nxt[DG_EXCESS] = 1'b0;
      end
      if (wr_cmd && wdata_i == CMD_ENABLE_TX) begin
         diag_nxt[DG_TXAV] = 1'b0;
      end
      if (self_reconfig) diag_nxt[DG_SELF] = 1'b1;
      if (dup_hit) diag_nxt[DG_DUP] = 1'b1;
      if (rx_level_r) diag_nxt[DG_RCV] = 1'b1;
      if (token_seen_i && !token_from_self_i) begin
         diag_nxt[DG_TOKEN] = 1'b1;
      end
      if (refuse_limit) diag_nxt[DG_EXCESS] = 1'b1;
      if (probe_hit) diag_nxt[DG_PROBE] = 1'b1;
      if (succ_changed) diag_nxt[DG_SUCC] = 1'b1;
      if (tx_abandoned_r && token_to_me_i) begin
         diag_nxt[DG_TXAV] = 1'b1;
      end
   end

   // Status flops and the refusal interrupt.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         diag_r <= RST_BYTE;
         excess_irq_o <= 1'b0;
      end else begin
         diag_r <= diag_nxt;
         excess_irq_o <= diag_nxt[DG_EXCESS];
      end
   end

   //=======================================================================
   // Buffer RAM write sequencer
   //=======================================================================
   seq_state_t seq_r;
   // Each identifier write stores the check pattern, then the identifier.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         seq_r <= SEQ_IDLE;
         ram_we_o <= 1'b0;
         ram_addr_o <= RAM_LOC_CHECK;
         ram_data_o <= RST_BYTE;
      end else begin
         unique case (seq_r)
            SEQ_IDLE: begin
               ram_we_o <= 1'b0;
               if (wr_sid) seq_r <= SEQ_CHECK;
            end
            SEQ_CHECK: begin
               ram_we_o <= 1'b1;
               ram_addr_o <= RAM_LOC_CHECK;
               ram_data_o <= RAM_CHECK_PATTERN;
               seq_r <= SEQ_ID;
            end
            SEQ_ID: begin
               ram_we_o <= 1'b1;
               ram_addr_o <= RAM_LOC_ID;
               ram_data_o <= station_id_r;
               seq_r <= wr_sid ? SEQ_CHECK : SEQ_IDLE;
            end
            default: seq_r <= SEQ_IDLE;
         endcase
      end
   end

   //=======================================================================
   // Checks
   //=======================================================================
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);
   sequence s_check_word;
      ram_we_o && ram_addr_o == RAM_LOC_CHECK &&
         ram_data_o == RAM_CHECK_PATTERN;
   endsequence
   sequence s_id_word;
      ram_we_o && ram_addr_o == RAM_LOC_ID;
   endsequence
   AST_RAM_PAIR: assert property (
      $rose(seq_r == SEQ_CHECK) |=> s_check_word ##1 s_id_word)
      else $error("identifier write missed its RAM pair");
   AST_ASLEEP_NO_TOKENS: assert property (
      !core_awake_o |=> !token_pass_en_o && !reconfig_start_o)
      else $error("sleeping core passed tokens or reconfigured");
   AST_JOIN_NEEDS_TRANSMIT_JOIN_ENABLE: assert property (
      token_pass_en_o |-> $past(transmit_join_enable))
      else $error("node joined without transmit enable");
   AST_ZERO_KEEPS_ASLEEP: assert property (
      station_id_r == RST_BYTE |=> !core_awake_o)
      else $error("zero identifier woke the core");
   AST_JOIN_RECONFIG: assert property (
      $rose(token_pass_en_o) |-> reconfig_start_o && diag_r[DG_SELF])
      else $error("join did not start a reconfiguration");
   AST_DIAG_READ_CLEARS: assert property (
      rd_diag && !dup_hit && !self_reconfig |=>
         !diag_r[DG_DUP] && !diag_r[DG_SELF])
      else $error("diagnostic read left flags set");
   AST_DUP_SETS: assert property (
      dup_hit |=> diag_r[DG_DUP])
      else $error("duplicate response not flagged");
   AST_TOKEN_SEEN: assert property (
      token_seen_i && !token_from_self_i |=> diag_r[DG_TOKEN])
      else $error("foreign token not flagged");
   AST_EXCESS_IRQ: assert property (
      refuse_limit |=> excess_irq_o && refuse_cnt_r == 7'h00)
      else $error("refusal limit did not raise interrupt");
   AST_TXAV: assert property (
      tx_abandoned_r && token_to_me_i |=> diag_r[DG_TXAV] && !tx_abandoned_r)
      else $error("transmitter not made available");
   AST_RX_ACT: assert property (
      rx_level_r |=> diag_r[DG_RCV])
      else $error("receive activity not flagged");
   AST_PROBE_NOT_SUCC: assert property (
      $rose(diag_r[DG_PROBE]) |-> $past(last_dest_r) != $past(next_id_r))
      else $error("probe reported the successor");
endmodule

// ===== peer_net_model.sv
`timescale 1ns/1ps
// ====================
// Peer nodes as seen through the protocol engine events.
module peer_net_model (
   // Clock.
   input wire logic clk_i,
   // Token traffic.
   output logic token_seen_o,
   output logic [7:0] token_dest_o,
   output logic token_from_self_o,
   output logic token_response_o,
   // Events: 0 token to us, 1 timer expiry, 2 refusal, 3 acceptance.
   output logic [3:0] event_o,
   // Levels.
   output logic [7:0] successor_o,
   output logic line_o
);
   // Everything starts idle.
   initial begin
      token_seen_o = 1'b0;
      token_dest_o = 8'h00;
      token_from_self_o = 1'b0;
      token_response_o = 1'b0;
      event_o = 4'h0;
      successor_o = 8'h00;
      line_o = 1'b0;
   end
   // One token passes; a peer answers it only when asked to.
   task automatic token(input logic [7:0] dest, input logic own,
                        input logic resp);
      @(posedge clk_i);
      token_seen_o <= 1'b1;
      token_dest_o <= dest;
      token_from_self_o <= own;
      @(posedge clk_i);
      token_seen_o <= 1'b0;
      token_from_self_o <= 1'b0;
      token_dest_o <= ~dest;
      token_response_o <= resp;
      @(posedge clk_i);
      token_response_o <= 1'b0;
   endtask
   // Single-cycle events, repeated n times with a gap between them.
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clk_i);
         event_o <= 4'h1 << k;
         @(posedge clk_i);
         event_o <= 4'h0;
      end
   endtask
   // The logical successor changes when nodes join or leave.
   task automatic set_succ(input logic [7:0] v);
      @(posedge clk_i);
      successor_o <= v;
   endtask
   // Activity on the receive line.
   task automatic set_line(input logic v);
      @(posedge clk_i);
      line_o <= v;
   endtask
endmodule

// ===== token_node_join_diagnostics_test.sv
`timescale 1ns/1ps
module token_node_join_diagnostics_test import token_node_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_n_i, wr_i, rd_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, tk_dest, succ, d, id, pr, sc;
   logic tk_seen, tk_self, tk_resp, line, awake, pass_en, reconf;
   logic irq, bus_det, ram_we;
   logic [3:0] ev;
   logic [10:0] ram_addr;
   logic [7:0] ram_data;
   int miscompares = 0;
   int num_checks = 0;
   int i;
   // ====================
   // Design and peers.
   token_node_join_diag u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .token_seen_i(tk_seen), .token_dest_i(tk_dest),
      .token_from_self_i(tk_self), .token_response_i(tk_resp),
      .token_to_me_i(ev[0]), .recv_timer_expired_i(ev[1]),
      .refusal_i(ev[2]), .accept_i(ev[3]), .successor_id_i(succ),
      .line_receive_input_i(line), .core_awake_o(awake),
      .token_pass_en_o(pass_en), .reconfig_start_o(reconf),
      .excess_irq_o(irq), .bus_detected_o(bus_det), .ram_we_o(ram_we),
      .ram_addr_o(ram_addr), .ram_data_o(ram_data));
   peer_net_model u_peer (.clk_i(clk_i), .token_seen_o(tk_seen),
      .token_dest_o(tk_dest), .token_from_self_o(tk_self),
      .token_response_o(tk_resp), .event_o(ev), .successor_o(succ),
      .line_o(line));
   // The clock toggles every half period of 2 ns.
   always #2 clk_i = ~clk_i;
   // ====================
   // Helpers.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Consecutive refusals that trip the flag.
   function automatic int refuse_limit(input logic short_sel);
      return short_sel ? 4 : 128;
   endfunction
   // Duplicate and token-seen bits expected after one token.
   function automatic logic [7:0] exp_diag(input logic [7:0] dst,
      input logic [7:0] me, input logic own, input logic rs);
      return {1'b0, dst == me && !own && rs, 1'b0, !own, 4'h0};
   endfunction
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // Reads the diagnostic status and compares one of its bits.
   task automatic diag_bit(input int b, input logic e);
      logic [7:0] v;
      repeat (2) @(posedge clk_i);
      reg_rd(OFS_DIAG, v);
      check({7'h00, v[b]}, {7'h00, e});
   endtask
   task automatic stop_test();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ====================
   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      stop_test();
   end
   // ====================
   // Main sequence.
   initial begin
      rst_n_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      void'($urandom(58));
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 check({7'h00, bus_det}, 8'h00);
      reg_wr(OFS_AUX_CONFIG, 8'h01);
      reg_rd(OFS_AUX_CONFIG, d);
      reg_rd(OFS_BUS_STATE, d);
      check(d & 8'h01, 8'h01);
      reg_rd(4'hf, d);
      check(d, 8'h00);
      // Asleep: neither transmit enable nor a zero identifier wakes it.
      reg_wr(OFS_CONFIG, 8'h20);
      repeat (4) @(posedge clk_i);
      #1 check({5'h00, reconf, awake, pass_en}, 8'h00);
      u_peer.pulse(1, 1);
      diag_bit(DG_SELF, 1'b0);
      reg_wr(OFS_CONFIG, 8'h00);
      reg_wr(OFS_STATION_ID, 8'h00);
      repeat (6) @(posedge clk_i);
      #1 check({7'h00, awake}, 8'h00);
      id = 8'($urandom_range(1, 126));
      sc = 8'h80 | 8'($urandom_range(0, 127));
      u_peer.set_succ(sc);
      reg_wr(OFS_STATION_ID, id);
      for (i = 0; i < 8 && ram_we !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      check({ram_we, ram_addr[6:0]}, 8'h80);
      check(ram_data, RAM_CHECK_PATTERN);
      @(posedge clk_i);
      #1 check({ram_we, ram_addr[6:0]}, 8'h81);
      check(ram_data, id);
      check({6'h00, awake, pass_en}, 8'h02);
      reg_rd(OFS_DIAG, d);
      // Token seen and duplicate detection before joining.
      u_peer.token(id ^ 8'h01, 1'b1, 1'b0);
      diag_bit(DG_TOKEN, 1'b0);
      u_peer.token(id ^ 8'h01, 1'b0, 1'b0);
      diag_bit(DG_TOKEN, 1'b1);
      u_peer.token(id, 1'b0, 1'b0);
      diag_bit(DG_DUP, 1'b0);
      u_peer.token(id, 1'b0, 1'b1);
      diag_bit(DG_DUP, 1'b1);
      diag_bit(DG_DUP, 1'b0);
      reg_wr(OFS_STATION_ID, id + 8'h01);
      repeat (6) @(posedge clk_i);
      u_peer.token(id, 1'b0, 1'b1);
      diag_bit(DG_DUP, 1'b0);
      id = id + 8'h01;
      // Receive line activity.
      u_peer.set_line(1'b1);
      repeat (8) @(posedge clk_i);
      u_peer.set_line(1'b0);
      repeat (6) @(posedge clk_i);
      diag_bit(DG_RCV, 1'b1);
      diag_bit(DG_RCV, 1'b0);
      // Probing for other nodes, and the successor exclusion.
      pr = {1'b0, 7'($urandom)};
      if (pr == id) begin
         pr = pr ^ 8'h01;
      end
      reg_wr(OFS_PROBE_ID, pr);
      u_peer.token(pr, 1'b0, 1'b1);
      diag_bit(DG_PROBE, 1'b1);
      reg_wr(OFS_PROBE_ID, sc);
      u_peer.token(sc, 1'b0, 1'b1);
      diag_bit(DG_PROBE, 1'b0);
      sc = sc ^ 8'h01;
      u_peer.set_succ(sc);
      diag_bit(DG_SUCC, 1'b1);
      reg_rd(OFS_NEXT_ID, d);
      check(d, sc);
      // Joining the network.
      reg_wr(OFS_CONFIG, 8'h20);
      for (i = 0; i < 6 && reconf !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      check({6'h00, reconf, pass_en}, 8'h03);
      diag_bit(DG_SELF, 1'b1);
      diag_bit(DG_SELF, 1'b0);
      u_peer.pulse(1, 1);
      diag_bit(DG_SELF, 1'b1);
      reg_wr(OFS_PROBE_ID, pr);
      u_peer.token(pr, 1'b0, 1'b1);
      diag_bit(DG_PROBE, 1'b1);
      // Refusal thresholds, both settings, each tripping twice.
      for (int s = 1; s >= 0; s--) begin
         reg_wr(OFS_AUX_CONFIG, 8'(s));
         reg_wr(OFS_COMMAND, CMD_CLEAR_POWER_FLAGS);
         for (int w = 0; w < 2; w++) begin
            u_peer.pulse(2, refuse_limit(s[0]) - 1);
            repeat (2) @(posedge clk_i);
            #1 check({7'h00, irq}, 8'h00);
            u_peer.pulse(2, 1);
            repeat (2) @(posedge clk_i);
            #1 check({7'h00, irq}, 8'h01);
            diag_bit(DG_EXCESS, 1'b1);
            reg_wr(OFS_COMMAND, CMD_CLEAR_POWER_FLAGS);
         end
      end
      // An acceptance breaks the run of refusals.
      reg_wr(OFS_AUX_CONFIG, 8'h01);
      u_peer.pulse(2, 3);
      u_peer.pulse(3, 1);
      u_peer.pulse(2, 3);
      repeat (2) @(posedge clk_i);
      #1 check({7'h00, irq}, 8'h00);
      // Transmitter available after the transmitter is disabled.
      reg_wr(OFS_COMMAND, CMD_ENABLE_TX);
      reg_wr(OFS_COMMAND, CMD_DISABLE_TX);
      diag_bit(DG_TXAV, 1'b0);
      u_peer.pulse(0, 1);
      diag_bit(DG_TXAV, 1'b1);
      // Random traffic against the duplicate and token-seen bits.
      for (i = 0; i < 24; i++) begin
         d = 8'($urandom_range(0, 7));
         pr = d[2] ? id : {1'b0, 7'($urandom)};
         d[1] = d[1] & ~d[0];
         u_peer.token(pr, d[0], d[1]);
         repeat (2) @(posedge clk_i);
         reg_rd(OFS_DIAG, sc);
         check(sc & 8'h50, exp_diag(pr, id, d[0], d[1]));
      end
      stop_test();
   end
endmodule
